// [include/sinc3_pkg.sv]
// Shared constants, types and register map of the sinc3 decimation filter
package sinc3_pkg;
	// ==========================================================
	// Clocking and decimation
	localparam int          MOD_DIV   = 128; // Master clocks per sample
	localparam int          DEC_W     = 9;
	localparam int          STAGES    = 3;
	localparam int          ACC_W     = STAGES * DEC_W + 1;
	localparam int          NUM_RATES = 4;
	localparam logic [8:0]  DEC_N0    = 9'h180; // 384: 50 Hz
	localparam logic [8:0]  DEC_N1    = 9'h140; // 320: 60 Hz
	localparam logic [8:0]  DEC_N2    = 9'h060; // 96: 200 Hz
	localparam logic [8:0]  DEC_N3    = 9'h028; // 40: 480 Hz

	// ==========================================================
	// Scaling: 5 percent headroom over the nominal span
	localparam int          HEAD_NUM  = 105;
	localparam int          HEAD_DEN  = 100;
	localparam int          SCALE_SH  = 24;
	localparam int          K_W       = 26;
	localparam logic [15:0] BIP_ZERO  = 16'h8000;
	localparam logic [15:0] CODE_MAX  = 16'hFFFF;

	function automatic logic [K_W-1:0] scaleOf(input logic [8:0] n);
		logic [63:0] cube;
		cube = 64'(n) * 64'(n) * 64'(n);
		return K_W'((64'(HEAD_NUM) << 40) / (64'(HEAD_DEN) * cube));
	endfunction

	function automatic logic [ACC_W-1:0] halfOf(input logic [8:0] n);
		return ACC_W'((64'(n) * 64'(n) * 64'(n)) >> 1);
	endfunction

	// ==========================================================
	// Settling periods
	localparam logic [2:0]  SETTLE_STEP = 3'h4;
	localparam logic [2:0]  SETTLE_SYNC = 3'h3;

	// ==========================================================
	// Register map (byte addresses) and fields
	localparam logic [3:0]  ADDR_CTRL   = 4'h0;
	localparam logic [3:0]  ADDR_STATUS = 4'h4;
	localparam logic [3:0]  ADDR_DATA   = 4'h8;
	localparam logic [3:0]  ADDR_RAW    = 4'hC;
	localparam logic [3:0]  CTRL_RESET  = 4'h8; // Run, bipolar, 50 Hz

	typedef struct packed {
		logic       run;
		logic       unipolar;
		logic       rate_select_bit1;
		logic       rate_select_bit0;
	} ctrl_t;

	typedef struct packed {
		logic       running;
		logic       overrange;
		logic       settled;
		logic       newData;
	} status_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK  = 2'b01
	} bus_state_t;
endpackage

// [verilog/sinc3_rate_gen.sv]
// Modulator sample tick and output period tick generator
`timescale 1ns/10ps
module sinc3_rate_gen #(
	parameter int MOD_DIV = 128,
	parameter int DEC_W   = 9
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic [DEC_W-1:0] decN,
	output logic                  modTick,
	output logic                  decTick
);
	localparam int DIV_W = $clog2(MOD_DIV);

	logic [DIV_W-1:0] divQ;
	logic [DEC_W-1:0] decQ;
	wire              divEnd = (divQ == DIV_W'(MOD_DIV - 1));
	wire              decEnd = (decQ >= decN - DEC_W'(1));

	// ==========================================================
	// Master clock divided down to the modulator rate
	// A clear realigns the modulator too, so the first period
	// after a restart is a whole one and settling stays exact
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			divQ    <= '0;
			modTick <= 1'b0;
		end else if (clear) begin
			divQ    <= '0;
			modTick <= 1'b0;
		end else begin
			divQ    <= divEnd ? '0 : divQ + DIV_W'(1);
			modTick <= divEnd;
		end
	end

	// Sample count per result; a clear restarts the period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			decQ    <= '0;
			decTick <= 1'b0;
		end else if (clear) begin
			decQ    <= '0;
			decTick <= 1'b0;
		end else begin
			decTick <= divEnd && decEnd;
			if (divEnd)
				decQ <= decEnd ? '0 : decQ + DEC_W'(1);
		end
	end
endmodule

// [verilog/sinc3_core.sv]
// Cascaded integrator-comb core giving the third-order sinc response
`timescale 1ns/10ps
module sinc3_core #(
	parameter int STAGES = 3,
	parameter int ACC_W  = 28
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic             sampleEn,
	input  wire logic             sampleBit,
	input  wire logic             decimEn,
	output logic [ACC_W-1:0]      result,
	output logic                  resultValid
);
	// Wrapping arithmetic is exact while ACC_W covers N cubed
	logic [ACC_W-1:0] integQ [STAGES];
	logic [ACC_W-1:0] delayQ [STAGES];
	logic [ACC_W-1:0] combIn [STAGES+1];

	assign combIn[0] = integQ[STAGES-1];

	// ==========================================================
	// One integrator and one comb per order
	for (genvar s = 0; s < STAGES; s++) begin : g_stage
		wire [ACC_W-1:0] integIn = (s == 0) ?
			ACC_W'(sampleBit) : integQ[(s == 0) ? 0 : s-1];
		assign combIn[s+1] = combIn[s] - delayQ[s];

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				integQ[s] <= '0;
				delayQ[s] <= '0;
			end else if (clear) begin
				integQ[s] <= '0;
				delayQ[s] <= '0;
			end else begin
				if (sampleEn)
					integQ[s] <= integQ[s] + integIn;
				if (decimEn)
					delayQ[s] <= combIn[s];
			end
		end
	end

	// Comb output taken once per output period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result      <= '0;
			resultValid <= 1'b0;
		end else begin
			resultValid <= decimEn && !clear;
			if (decimEn)
				result <= combIn[STAGES];
		end
	end
endmodule

// [verilog/sinc3_filter.sv]
// Sinc3 decimation filter top with Avalon-MM register access
//
// Summary of operation
// - The bitstream is filtered by three cascaded N-tap averages, scaled by 1/N each.
// - N is the modulator rate divided by the chosen output rate.
// - One result is produced per N samples, the first notch frequency.
// - Notches fall at every multiple of the first notch except multiples of the sample rate, by structure.
// - The two rate bits pick N only, so the response shape never changes.
// - After a step or rate change four output periods pass before data is valid.
// - After filter sync the filter restarts and is valid after three periods.
// - The modulator delivers samples at master clock over 128, then decimated.
// - The datapath keeps 5 percent headroom over nominal range without wrapping.
// - The polarity bit changes only output coding, not the filtering.
// - Images at multiples of the sample rate pass, as the comb cannot reject them.
// - The rate bits place the first notch between 50 Hz and 500 Hz.
// - The modulator rate is the master clock over 128 regardless of gain.
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module sinc3_filter
	import sinc3_pkg::*;
#(
	parameter int MOD_DIV = sinc3_pkg::MOD_DIV
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [3:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest,
	input  wire logic         modBit,
	input  wire logic         filterSync,
	output logic              modSampleTick,
	output logic [15:0]       resultData,
	output logic              resultNew,
	output sinc3_pkg::ctrl_t  ctrlOut
);
	import sinc3_pkg::*;

	// ==========================================================
	// Declarations
	ctrl_t            ctrl_q;
	ctrl_t            ctrl_d;
	status_t          status;
	bus_state_t       busState_q;
	logic             newData_q;
	logic             overrange_q;
	logic [2:0]       settle_q;
	logic             syncPrev_q;
	logic             runPrev_q;
	logic [1:0]       ratePrev_q;
	logic [15:0]      data_q;
	logic [ACC_W-1:0] raw_q;
	logic             modTick;
	logic             decTick;
	logic [ACC_W-1:0] cicOut;
	logic             cicValid;
	logic [15:0]      code;
	logic             clipped;

	// ==========================================================
	// Rate selection
	// The table stays inside 50..500 Hz at the nominal clock
	wire [1:0] rateSel = {ctrl_q.rate_select_bit1,
		ctrl_q.rate_select_bit0};
	wire [DEC_W-1:0] decN =
		(rateSel == 2'h0) ? DEC_N0 :
		(rateSel == 2'h1) ? DEC_N1 :
		(rateSel == 2'h2) ? DEC_N2 : DEC_N3;

	wire [K_W-1:0] scaleK =
		(rateSel == 2'h0) ? scaleOf(DEC_N0) :
		(rateSel == 2'h1) ? scaleOf(DEC_N1) :
		(rateSel == 2'h2) ? scaleOf(DEC_N2) : scaleOf(DEC_N3);

	wire [ACC_W-1:0] halfScale =
		(rateSel == 2'h0) ? halfOf(DEC_N0) :
		(rateSel == 2'h1) ? halfOf(DEC_N1) :
		(rateSel == 2'h2) ? halfOf(DEC_N2) : halfOf(DEC_N3);

	// ==========================================================
	// Restart conditions
	// Sync holds the filter cleared; its release aligns the step
	wire syncHeld   = filterSync;
	wire syncRel    = syncPrev_q && !filterSync;
	wire runStart   = ctrl_q.run && !runPrev_q;
	wire rateChange = (ratePrev_q != rateSel);
	wire cicClear   = syncHeld || !ctrl_q.run || runStart;

	// ==========================================================
	// Modulator rate and decimation timing
	sinc3_rate_gen #(
		.MOD_DIV (MOD_DIV),
		.DEC_W   (DEC_W)
	) u_rate (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.clear   (cicClear),
		.decN    (decN),
		.modTick (modTick),
		.decTick (decTick)
	);

	// ==========================================================
	// Integrator-comb core, one bit in per modulator sample
	// Gives nulls at k times the output rate but none at the
	// sample rate itself, so those images reach the output
	sinc3_core #(
		.STAGES      (STAGES),
		.ACC_W       (ACC_W)
	) u_core (
		.clk         (ref_clk),
		.rst_n       (rst_n),
		.clear       (cicClear),
		.sampleEn    (modTick),
		.sampleBit   (modBit),
		.decimEn     (decTick),
		.result      (cicOut),
		.resultValid (cicValid)
	);

	// ==========================================================
	// Normalisation by 1/N cubed with headroom
	// Mid density is input zero; full scale sits 5 percent
	// inside the density limits so excursions do not wrap
	wire signed [ACC_W:0] centred =
		$signed({1'b0, cicOut}) - $signed({1'b0, halfScale});
	wire signed [ACC_W+K_W+1:0] scaled =
		centred * $signed({1'b0, scaleK});
	wire signed [ACC_W+K_W+1:0] bipShift = scaled >>> SCALE_SH;
	wire signed [ACC_W+K_W+1:0] uniShift = scaled >>> (SCALE_SH - 1);

	// Offset binary for bipolar, straight binary for unipolar
	wire signed [ACC_W+K_W+1:0] bipVal =
		bipShift + $signed({1'b0, BIP_ZERO});
	wire signed [ACC_W+K_W+1:0] codeVal =
		ctrl_q.unipolar ? uniShift : bipVal;

	wire codeLow  = codeVal < 0;
	wire codeHigh = codeVal > $signed({1'b0, CODE_MAX});

	// Clip only at the coding stage, never inside the filter
	assign clipped = codeLow || codeHigh;
	assign code    = codeLow  ? 16'h0000 :
	                 codeHigh ? CODE_MAX : codeVal[15:0];

	// ==========================================================
	// Settling tracker
	// A step is not visible here, so a rate change is treated as
	// the worst case and costs four periods; a sync costs three
	wire settled    = (settle_q == 3'h0);
	wire lastStep   = (settle_q == 3'h1);
	wire settleLoad = syncRel || runStart;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_q <= SETTLE_STEP;
		end else if (settleLoad) begin
			settle_q <= SETTLE_SYNC;
		end else if (rateChange) begin
			settle_q <= SETTLE_STEP;
		end else if (cicValid && !settled) begin
			settle_q <= settle_q - 3'h1;
		end
	end

	// Edge history for restart detection
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncPrev_q <= 1'b0;
			runPrev_q  <= 1'b0;
			ratePrev_q <= 2'h0;
		end else begin
			syncPrev_q <= filterSync;
			runPrev_q  <= ctrl_q.run;
			ratePrev_q <= rateSel;
		end
	end

	// ==========================================================
	// Output data register
	// Each result lands here every period; only settled ones
	// are flagged as new
	// The result that empties the settle count is already good
	wire goodResult = cicValid && (settled || lastStep) && !rateChange;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_q      <= 16'h0000;
			raw_q       <= '0;
			overrange_q <= 1'b0;
		end else if (cicValid) begin
			data_q      <= code;
			raw_q       <= cicOut;
			overrange_q <= clipped;
		end
	end

	// ==========================================================
	// Avalon-MM slave
	// Every access takes one wait cycle, which keeps readdata
	// and waitrequest straight from flip-flops
	wire busReq  = avs_read || avs_write;
	wire accept  = busReq && (busState_q == BUS_IDLE);
	wire commit  = busReq && (busState_q == BUS_ACK);
	wire selCtrl = (avs_address == ADDR_CTRL);
	wire selStat = (avs_address == ADDR_STATUS);
	wire selData = (avs_address == ADDR_DATA);
	wire selRaw  = (avs_address == ADDR_RAW);
	wire ctrlWr  = commit && avs_write && selCtrl && avs_byteenable[0];
	wire dataRd  = commit && avs_read && selData;

	// Status view of the running filter
	assign status.running   = ctrl_q.run && !syncHeld;
	assign status.overrange = overrange_q;
	assign status.settled   = settled;
	assign status.newData   = newData_q;

	// Read mux; unmapped addresses read as zero
	wire [31:0] readMux =
		selCtrl ? {28'h0000000, ctrl_q} :
		selStat ? {28'h0000000, status} :
		selData ? {16'h0000, data_q} :
		selRaw  ? {{(32-ACC_W){1'b0}}, raw_q} : 32'h00000000;

	assign ctrl_d = ctrlWr ? ctrl_t'(avs_writedata[3:0]) : ctrl_q;

	// Handshake state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busState_q      <= BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			busState_q      <= accept ? BUS_ACK : BUS_IDLE;
			avs_waitrequest <= !accept;
		end
	end

	// Read data captured as the request is accepted
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h00000000;
		end else if (accept && avs_read) begin
			avs_readdata <= readMux;
		end
	end

	// Control register, written on the completing edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= ctrl_t'(CTRL_RESET);
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// New word flag: a fresh result wins over the read clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			newData_q <= 1'b0;
		end else if (goodResult) begin
			newData_q <= 1'b1;
		end else if (dataRd || rateChange || settleLoad) begin
			newData_q <= 1'b0;
		end
	end

	// ==========================================================
	// Direct outputs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			modSampleTick <= 1'b0;
			resultData    <= 16'h0000;
			resultNew     <= 1'b0;
			ctrlOut       <= ctrl_t'(CTRL_RESET);
		end else begin
			modSampleTick <= modTick;
			resultNew     <= goodResult;
			ctrlOut       <= ctrl_q;
			if (goodResult)
				resultData <= code;
		end
	end
endmodule

// [verif/sigma_mod_model.sv]
// Modulator bitstream source standing in front of the filter
`timescale 1ns/10ps
module sigma_mod_model (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       modSampleTick,
	input  wire logic [1:0] pattern,
	output logic            modBit
);
	// One new bit per sample, moved just after the tick so it is
	// stable long before the filter samples it again
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			modBit <= 1'b0;
		end else if (modSampleTick) begin
			case (pattern)
				2'h0: modBit <= 1'b0;
				2'h1: modBit <= 1'b1;
				2'h2: modBit <= !modBit;
				default: modBit <= 1'($urandom);
			endcase
		end
	end
endmodule

// [verif/sinc3_filter_asserts.sv]
// Port checker for the sinc3 filter, bound to its top module
`timescale 1ns/10ps
module sinc3_filter_asserts
	import sinc3_pkg::*;
#(
	parameter int MOD_DIV = 128
) (
	input wire logic             ref_clk,
	input wire logic             rst_n,
	input wire logic             avs_read,
	input wire logic             avs_write,
	input wire logic             avs_waitrequest,
	input wire logic             filterSync,
	input wire logic             modSampleTick,
	input wire logic [15:0]      resultData,
	input wire logic             resultNew,
	input wire sinc3_pkg::ctrl_t ctrlOut
);
	// ==========================================================
	// Helper logic
	int    tickGap;
	int    resGap;
	int    since;
	int    decN;
	logic  tickSeen;
	logic  resSeen;
	ctrl_t ctrlPrev_q;
	wire logic [1:0] rate = {ctrlOut.rate_select_bit1,
		ctrlOut.rate_select_bit0};
	wire logic hold = filterSync || !ctrlOut.run;
	wire logic rateChg = rate != {ctrlPrev_q.rate_select_bit1,
		ctrlPrev_q.rate_select_bit0};
	// Any disturbance voids the spacing history
	wire logic upset = hold || (ctrlOut != ctrlPrev_q);
	assign decN = rate == 2'h0 ? int'(DEC_N0) : rate == 2'h1 ?
		int'(DEC_N1) : rate == 2'h2 ? int'(DEC_N2) : int'(DEC_N3);

	// Cycle counters since the last tick, result and restart
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlPrev_q <= ctrl_t'(CTRL_RESET);
			tickGap <= 0;
			resGap <= 0;
			since <= 0;
			tickSeen <= 1'b0;
			resSeen <= 1'b0;
		end else begin
			ctrlPrev_q <= ctrlOut;
			tickGap <= modSampleTick ? 0 : tickGap + 1;
			resGap <= resultNew ? 0 : resGap + 1;
			since <= (hold || rateChg) ? 0 : since + 1;
			tickSeen <= !upset && (tickSeen || modSampleTick);
			resSeen <= !upset && (resSeen || resultNew);
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ans;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	property p_tickGap;
		tickSeen && !upset && modSampleTick |-> tickGap == MOD_DIV - 1;
	endproperty
	property p_tickBound;
		tickSeen && !upset |-> tickGap < MOD_DIV;
	endproperty
	property p_resGap;
		resSeen && !upset && resultNew |-> resGap == decN * MOD_DIV - 1;
	endproperty
	property p_heldQuiet;
		hold [*3] |-> !resultNew;
	endproperty
	property p_settle;
		resultNew |-> since >= 3 * decN * MOD_DIV;
	endproperty
	property p_busAnswer;
		s_req |=> s_ans;
	endproperty
	property p_waitIdle;
		!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest;
	endproperty
	property p_dataOnlyNew;
		!$stable(resultData) |-> resultNew;
	endproperty
	a_tickGap: assert property (p_tickGap)
		else $error("sample tick spacing off");
	a_tickBound: assert property (p_tickBound)
		else $error("sample tick missing");
	a_resGap: assert property (p_resGap)
		else $error("result spacing off");
	a_heldQuiet: assert property (p_heldQuiet)
		else $error("result while held");
	a_settle: assert property (p_settle)
		else $error("result before settling");
	a_busAnswer: assert property (p_busAnswer)
		else $error("bus answer late or long");
	a_waitIdle: assert property (p_waitIdle)
		else $error("answer without request");
	a_dataOnlyNew: assert property (p_dataOnlyNew)
		else $error("data changed without flag");
endmodule

bind sinc3_filter sinc3_filter_asserts #(.MOD_DIV(MOD_DIV)) chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.filterSync(filterSync), .modSampleTick(modSampleTick),
	.resultData(resultData), .resultNew(resultNew), .ctrlOut(ctrlOut));

// [verif/sinc3_filter_bench.sv]
// Self-checking bench for the sinc3 decimation filter
`timescale 1ns/10ps
module sinc3_filter_bench;
	import sinc3_pkg::*;
	localparam int MD = 4; // Short modulator divide for speed
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        modBit;
	logic        filterSync = 1'b0;
	logic        modSampleTick;
	logic [15:0] resultData;
	logic        resultNew;
	ctrl_t       ctrlOut;
	logic [1:0]  pattern = 2'h1;
	logic [31:0] rd;
	int          bad_count = 0;
	int          checked = 0;
	int          n;
	int          t;
	int          r;
	int          j;
	int          rates[$] = '{int'(DEC_N0), int'(DEC_N1),
		int'(DEC_N2), int'(DEC_N3)};
	// Coding table: bit pattern, unipolar, expected code
	logic [1:0]  pats[$] = '{2'h2, 2'h2, 2'h0, 2'h1};
	logic        unis[$] = '{1'b0, 1'b1, 1'b0, 1'b1};
	logic [15:0] codes[$] = '{BIP_ZERO, 16'h0, 16'h0, CODE_MAX};

	always #10 ref_clk = !ref_clk;

	sinc3_filter #(.MOD_DIV(MD)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .modBit(modBit),
		.filterSync(filterSync), .modSampleTick(modSampleTick),
		.resultData(resultData), .resultNew(resultNew),
		.ctrlOut(ctrlOut));
	sigma_mod_model model (.ref_clk(ref_clk), .rst_n(rst_n),
		.modSampleTick(modSampleTick), .pattern(pattern), .modBit(modBit));

	// ==========================================================
	// Tasks
	task automatic test_done;
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic hang;
		bad_count++;
		$display("wrong value at %0t: wait ran out", $time);
		test_done;
	endtask
	// Held until waitrequest is seen low, then released for a cycle
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge ref_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (avs_waitrequest !== 1'b0) hang;
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic waitNew(input int lim);
		t = 0;
		do begin
			@(posedge ref_clk);
			t++;
		end while (resultNew !== 1'b1 && t < lim);
		if (resultNew !== 1'b1) hang;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h3CF33E70));
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk(32'(ctrlOut), 32'(CTRL_RESET));
		// Refused writes leave the control word alone
		bus(1'b1, ADDR_STATUS, 32'hF, 4'hF);
		bus(1'b1, ADDR_CTRL, 32'h3, 4'hE);
		bus(1'b0, ADDR_CTRL, 32'h0, 4'hF);
		chk(rd, 32'(CTRL_RESET));
		bus(1'b0, 4'h2, 32'h0, 4'hF);
		chk(rd, 32'h0);
		// Every rate code with a full-ones stream; each pass is a
		// real rate change, so the step settling applies every time
		for (int i = 0; i < 4; i++) begin
			j = (i + 1) % 4;
			bus(1'b1, ADDR_CTRL, 32'(8 + j), 4'h1);
			n = rates[j] * MD;
			waitNew(8 * n);
			chk(32'(t >= 3 * n), 32'h1);
			waitNew(2 * n);
			chk(t, n);
			bus(1'b0, ADDR_RAW, 32'h0, 4'hF);
			chk(rd, rates[j] ** 3);
			bus(1'b0, ADDR_STATUS, 32'h0, 4'hF);
			chk(rd, 32'hF);
			bus(1'b0, ADDR_DATA, 32'h0, 4'hF);
			chk(rd, 32'(CODE_MAX));
			bus(1'b0, ADDR_STATUS, 32'h0, 4'hF);
			chk(rd, 32'hE);
		end
		// Output coding after a step, fastest rate
		n = rates[3] * MD;
		for (int i = 0; i < 4; i++) begin
			pattern <= pats[i];
			bus(1'b1, ADDR_CTRL, {28'h0, 1'b1, unis[i], 2'h3}, 4'h1);
			repeat (5) waitNew(8 * n);
			chk(32'(resultData), 32'(codes[i]));
		end
		// Random stream and rate, then a sync restart
		pattern <= 2'h3;
		r = $urandom % 4;
		n = rates[r] * MD;
		bus(1'b1, ADDR_CTRL, 32'(8 + r), 4'h1);
		waitNew(8 * n);
		waitNew(2 * n);
		chk(t, n);
		filterSync <= 1'b1;
		repeat (10) @(posedge ref_clk);
		filterSync <= 1'b0;
		waitNew(8 * n);
		chk(32'(t >= 3 * n - MD && t <= 3 * n + 4 * MD), 32'h1);
		test_done;
	end
endmodule
